// [rtl/utx_pkg.sv]
// utx_pkg: register map, field positions, timing counts and carrier types
package utx_pkg;
  // ******************************
  // register byte addresses
  // ******************************
  localparam logic [7:0] ADR_CMD = 8'h00;
  localparam logic [7:0] ADR_STAT = 8'h04;
  localparam logic [7:0] ADR_TXB = 8'h08;
  localparam logic [7:0] ADR_FMT = 8'h0C;
  localparam logic [7:0] ADR_DIVH = 8'h10;
  localparam logic [7:0] ADR_DIVL = 8'h14;
  localparam logic [7:0] ADR_CSRC = 8'h18;
  localparam logic [7:0] ADR_MCTL = 8'h1C;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  // ******************************
  // channel_command codes
  // ******************************
  localparam logic [2:0] C_EN = 3'h1;
  localparam logic [2:0] C_DIS = 3'h2;
  localparam logic [2:0] C_RST = 3'h3;
  localparam logic [2:0] C_BRK_ON = 3'h4;
  localparam logic [2:0] C_BRK_OFF = 3'h5;
  localparam logic [2:0] C_RTS_ON = 3'h6;
  localparam logic [2:0] C_RTS_OFF = 3'h7;
  // ******************************
  // field positions and reset values
  // ******************************
  localparam int FMT_PEN = 2;
  localparam int FMT_PODD = 3;
  localparam int FMT_STOP2 = 4;
  localparam int FMT_CTS = 5;
  localparam int FMT_ARTS = 6;
  localparam logic [6:0] FMT_RST = 7'h03;
  localparam int MC_DTS = 2;
  localparam int MC_SHIFT_DIRECTION = 3;
  localparam int MC_AWR = 4;
  localparam int MC_COLD_RESET_INDICATION = 7;
  localparam logic [7:0] MC_MASK = 8'h9F;
  localparam logic [7:0] MC_RST = 8'h80;
  localparam logic [7:0] DIVH_RST = 8'h00;
  localparam logic [7:0] DIVL_RST = 8'h01;
  localparam int ST_TRDY = 0;
  localparam int ST_TEMP = 1;
  localparam int ST_CRDY = 2;
  localparam int ST_PDN = 3;
  localparam int ST_RTS = 4;
  localparam logic [1:0] CS_SYS = 2'h0;
  localparam logic [1:0] CS_EXT1 = 2'h1;
  localparam logic [1:0] CS_EXT16 = 2'h2;
  localparam logic [3:0] SYNC_RST = 4'h0;
  // ******************************
  // timing
  // ******************************
  localparam int PRESCALE = 32;
  localparam int EXT_DIV = 16;
  localparam int CLK_MHZ = 25;
  localparam int AWR_MIN_NS = 1000;
  localparam int AWR_MIN_CYC = (AWR_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam logic [7:0] AC_FS_LEN = 8'h10;
  localparam logic [3:0] AC_LAST_SLOT = 4'hC;
  localparam logic [4:0] AC_SLOT0_TOP = 5'h0F;
  localparam logic [4:0] AC_SLOT_TOP = 5'h13;
  localparam logic [7:0] PD_ADDR = 8'h26;
  localparam int PD_BIT = 12;
  // ******************************
  // types
  // ******************************
  typedef enum logic [1:0] {
    MD_UART = 2'b00, MD_C8 = 2'b01, MD_C16 = 2'b10, MD_AC97 = 2'b11
  } utx_mode_t;
  typedef enum logic [4:0] {
    S_IDLE = 5'b00001, S_START = 5'b00010, S_DATA = 5'b00100, S_PAR = 5'b01000, S_STOP = 5'b10000
  } utx_state_t;
  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } utx_axi_req_t;
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } utx_axi_rsp_t;
endpackage

// [rtl/utx_top.sv]
// utx_top: serial transmitter, baud generator and codec link behind AXI4-Lite
// Behaviour
// - system clock divided by 32, then divider
// - source select: system, external x1, external /16
// - ready flag when enabled and holding free
// - start, data lsb first, parity, stop bits
// - idle mark and empty flag until loaded
// - disable finishes the character in flight
// - software reset stops serial and codec transmission at once
// - clear-to-send gates character starts only
// - break drives low, ignores clear-to-send
// - auto negate request one bit later
// - reset selects plain serial mode
// - partner clocks; frame sync in or out
// - codec sample starts at sync, optional delay
// - shift direction; zeros after the sample
// - AC'97 slot data one clock after sync
// - AC'97 frame 256 clocks, sync 16 high
// - zeros until codec ready, start next frame
// - stop after frame with first bit low
// - fill all 13 slots from holding data
// - detect power-down request across slots 1-3
// - warm reset bit negates frame sync
// - modem idle low, change on clock rise
//
// The address map and the AXI4-Lite slave port were chosen for this implementation.
module utx_top (
  input wire logic clk_sys, // system clock, 25 MHz
  input wire logic arst_n, // asynchronous reset, active low
  input wire utx_pkg::utx_axi_req_t axi_req, // AXI4-Lite master side
  output utx_pkg::utx_axi_rsp_t axi_rsp, // AXI4-Lite slave side
  input wire logic cts_pin, // clear-to-send, low active; bit clock in modem modes
  input wire logic external_timer_clock_pin, // external baud clock
  input wire logic codec_frame_sync_pin, // codec frame sync
  input wire logic rxd, // serial input, watched for codec ready
  output logic txd, // serial output
  output logic rts_pin // request-to-send, low active; frame sync in AC'97 mode
);
  import utx_pkg::*;

  // ******************************
  // input synchronisers
  // ******************************
  logic [3:0] s1_r, s2_r;
  logic [1:0] s3_r;
  // two flops per pin, third only for edge detect
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s1_r <= SYNC_RST;
      s2_r <= SYNC_RST;
      s3_r <= SYNC_RST[1:0];
    end else begin
      s1_r <= {rxd, codec_frame_sync_pin, external_timer_clock_pin, cts_pin};
      s2_r <= s1_r;
      s3_r <= s2_r[1:0];
    end
  end
  wire cts_s = s2_r[0];
  wire fs_s = s2_r[2];
  wire rxd_s = s2_r[3];
  wire bclk_rise = s2_r[0] & ~s3_r[0];
  wire bclk_fall = ~s2_r[0] & s3_r[0];
  wire ext_fall = ~s2_r[1] & s3_r[1];

  // ******************************
  // AXI4-Lite slave
  // ******************************
  logic aw_ok_r, w_ok_r, awrdy_r, wrdy_r, bval_r, arrdy_r, rval_r;
  logic [7:0] wa_r;
  logic [31:0] wd_r, rdata_r, rd_val;
  logic [3:0] ws_r;
  logic [1:0] bresp_r, rresp_r;
  logic wr_hit, rd_hit;
  wire wr_do = aw_ok_r & w_ok_r & ~bval_r;
  assign axi_rsp = '{awready: awrdy_r, wready: wrdy_r, bvalid: bval_r, bresp: bresp_r,
                     arready: arrdy_r, rvalid: rval_r, rdata: rdata_r, rresp: rresp_r};
  // write address and data taken in either order
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      aw_ok_r <= 1'b0;
      w_ok_r <= 1'b0;
      awrdy_r <= 1'b0;
      wrdy_r <= 1'b0;
      wa_r <= 8'h00;
      wd_r <= 32'h0000_0000;
      ws_r <= 4'h0;
    end else begin
      if (awrdy_r && axi_req.awvalid) begin
        aw_ok_r <= 1'b1;
        awrdy_r <= 1'b0;
        wa_r <= axi_req.awaddr;
      end else if (!aw_ok_r && !bval_r) begin
        awrdy_r <= 1'b1;
      end
      if (wrdy_r && axi_req.wvalid) begin
        w_ok_r <= 1'b1;
        wrdy_r <= 1'b0;
        wd_r <= axi_req.wdata;
        ws_r <= axi_req.wstrb;
      end else if (!w_ok_r && !bval_r) begin
        wrdy_r <= 1'b1;
      end
      if (wr_do) begin
        aw_ok_r <= 1'b0;
        w_ok_r <= 1'b0;
      end
    end
  end
  // write response follows the completed write
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      bval_r <= 1'b0;
      bresp_r <= RESP_OK;
    end else if (wr_do) begin
      bval_r <= 1'b1;
      bresp_r <= wr_hit ? RESP_OK : RESP_ERR;
    end else if (bval_r && axi_req.bready) begin
      bval_r <= 1'b0;
    end
  end
  // read channel, data one cycle after the address is taken
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      arrdy_r <= 1'b0;
      rval_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= RESP_OK;
    end else if (arrdy_r && axi_req.arvalid) begin
      arrdy_r <= 1'b0;
      rval_r <= 1'b1;
      rdata_r <= rd_val;
      rresp_r <= rd_hit ? RESP_OK : RESP_ERR;
    end else if (rval_r && axi_req.rready) begin
      rval_r <= 1'b0;
    end else if (!rval_r) begin
      arrdy_r <= 1'b1;
    end
  end

  // ******************************
  // registers
  // ******************************
  logic [6:0] fmt_r;
  logic [7:0] divh_r, divl_r, mctl_r;
  logic [1:0] csrc_r;
  logic [4:0] stat;
  wire wlane = ws_r[0];
  wire cmd_stb = wr_do & wlane & (wa_r == ADR_CMD);
  wire txb_wr = wr_do & wlane & (wa_r == ADR_TXB);
  wire div_wr = wr_do & wlane & ((wa_r == ADR_DIVH) | (wa_r == ADR_DIVL));
  wire [2:0] cmd = wd_r[2:0];
  utx_mode_t mode;
  assign mode = utx_mode_t'(mctl_r[1:0]);
  wire uart = (mode == MD_UART);
  wire codec = (mode == MD_C8) | (mode == MD_C16);
  wire ac97 = (mode == MD_AC97);
  // write address decode
  always_comb begin
    wr_hit = 1'b1;
    if (wa_r == ADR_CMD) wr_hit = 1'b1;
    else if (wa_r == ADR_STAT) wr_hit = 1'b1;
    else if (wa_r == ADR_TXB) wr_hit = 1'b1;
    else if (wa_r == ADR_FMT) wr_hit = 1'b1;
    else if (wa_r == ADR_DIVH) wr_hit = 1'b1;
    else if (wa_r == ADR_DIVL) wr_hit = 1'b1;
    else if (wa_r == ADR_CSRC) wr_hit = 1'b1;
    else if (wa_r == ADR_MCTL) wr_hit = 1'b1;
    else wr_hit = 1'b0;
  end
  // read address decode
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    if (axi_req.araddr == ADR_CMD) rd_val = 32'h0000_0000;
    else if (axi_req.araddr == ADR_STAT) rd_val = {27'h0, stat};
    else if (axi_req.araddr == ADR_TXB) rd_val = 32'h0000_0000;
    else if (axi_req.araddr == ADR_FMT) rd_val = {25'h0, fmt_r};
    else if (axi_req.araddr == ADR_DIVH) rd_val = {24'h0, divh_r};
    else if (axi_req.araddr == ADR_DIVL) rd_val = {24'h0, divl_r};
    else if (axi_req.araddr == ADR_CSRC) rd_val = {30'h0, csrc_r};
    else if (axi_req.araddr == ADR_MCTL) rd_val = {24'h0, mctl_r};
    else rd_hit = 1'b0;
  end
  // configuration storage; mode field resets to plain serial
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      fmt_r <= FMT_RST;
      divh_r <= DIVH_RST;
      divl_r <= DIVL_RST;
      csrc_r <= CS_SYS;
      mctl_r <= MC_RST;
    end else if (wr_do && wlane) begin
      if (wa_r == ADR_FMT) fmt_r <= wd_r[6:0];
      else if (wa_r == ADR_DIVH) divh_r <= wd_r[7:0];
      else if (wa_r == ADR_DIVL) divl_r <= wd_r[7:0];
      else if (wa_r == ADR_CSRC) csrc_r <= wd_r[1:0];
      else if (wa_r == ADR_MCTL) mctl_r <= wd_r[7:0] & MC_MASK;
    end
  end

  // ******************************
  // baud clock generator
  // ******************************
  logic [4:0] pre_r;
  logic [15:0] dcnt_r;
  logic [3:0] e16_r;
  logic reload_r;
  wire pre_tick = (pre_r == 5'(PRESCALE - 1));
  wire term = pre_tick & (dcnt_r <= 16'h0001);
  logic bit_tick;
  // prescaler and divider; divider reloads one cycle after a write
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pre_r <= 5'h00;
      dcnt_r <= 16'h0001;
      reload_r <= 1'b0;
    end else begin
      pre_r <= pre_tick ? 5'h00 : pre_r + 5'h01;
      reload_r <= div_wr;
      if (reload_r || term) dcnt_r <= {divh_r, divl_r};
      else if (pre_tick) dcnt_r <= dcnt_r - 16'h0001;
    end
  end
  // external clock edge counter for divide by 16
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) e16_r <= 4'h0;
    else if (ext_fall) e16_r <= e16_r + 4'h1;
  end
  always_comb begin
    if (csrc_r == CS_EXT1) bit_tick = ext_fall;
    else if (csrc_r == CS_EXT16) bit_tick = ext_fall & (e16_r == 4'(EXT_DIV - 1));
    else bit_tick = term & ~reload_r;
  end

  // ******************************
  // transmitter control
  // ******************************
  logic en_r, brk_r, hold_full_r, rts_as_r, rts_pend_r;
  logic [19:0] hold_r;
  utx_state_t st_r;
  logic [7:0] sh_r;
  logic [2:0] cnt_r;
  logic par_r, line_r, hold_take;
  wire tx_rst = cmd_stb & (cmd == C_RST);
  wire cts_ok = ~fmt_r[FMT_CTS] | ~cts_s;
  wire can_start = uart & en_r & hold_full_r & ~brk_r & cts_ok;
  wire last_data = (cnt_r == (3'h4 + {1'b0, fmt_r[1:0]}));
  wire stop_done = (st_r == S_STOP) & (cnt_r >= {2'b00, fmt_r[FMT_STOP2]});
  wire char_done = bit_tick & uart & stop_done & ~can_start;
  // enable, break and request-to-send commands
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      en_r <= 1'b0;
      brk_r <= 1'b0;
      rts_as_r <= 1'b0;
      rts_pend_r <= 1'b0;
    end else begin
      if (tx_rst) begin
        en_r <= 1'b0;
        brk_r <= 1'b0;
      end else if (cmd_stb && cmd == C_EN) en_r <= 1'b1;
      else if (cmd_stb && cmd == C_DIS) en_r <= 1'b0;
      else if (cmd_stb && cmd == C_BRK_ON) brk_r <= 1'b1;
      else if (cmd_stb && cmd == C_BRK_OFF) brk_r <= 1'b0;
      if (cmd_stb && cmd == C_RTS_ON) begin
        rts_as_r <= 1'b1;
        rts_pend_r <= 1'b0;
      end else if (cmd_stb && cmd == C_RTS_OFF) rts_as_r <= 1'b0;
      else if (char_done && !en_r && fmt_r[FMT_ARTS]) rts_pend_r <= 1'b1;
      else if (rts_pend_r && bit_tick) begin
        rts_as_r <= 1'b0;
        rts_pend_r <= 1'b0;
      end
    end
  end
  // holding register; a write in the take cycle is kept
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      hold_full_r <= 1'b0;
      hold_r <= 20'h00000;
    end else if (tx_rst) begin
      hold_full_r <= 1'b0;
    end else if (txb_wr) begin
      hold_full_r <= 1'b1;
      hold_r <= wd_r[19:0];
    end else if (hold_take) begin
      hold_full_r <= 1'b0;
    end
  end
  // character framing state machine, one bit per tick
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= S_IDLE;
      sh_r <= 8'h00;
      cnt_r <= 3'h0;
      par_r <= 1'b0;
      line_r <= 1'b1;
    end else if (tx_rst || !uart) begin
      st_r <= S_IDLE;
      line_r <= 1'b1;
    end else if (bit_tick) begin
      case (st_r)
        S_IDLE, S_STOP: begin
          if ((st_r == S_IDLE || stop_done) && can_start) begin
            st_r <= S_START;
            sh_r <= hold_r[7:0];
            par_r <= fmt_r[FMT_PODD];
            line_r <= 1'b0;
          end else if (st_r == S_STOP && !stop_done) begin
            cnt_r <= cnt_r + 3'h1;
          end else begin
            st_r <= S_IDLE;
            line_r <= 1'b1;
          end
        end
        S_START: begin
          st_r <= S_DATA;
          cnt_r <= 3'h0;
          line_r <= sh_r[0];
          par_r <= par_r ^ sh_r[0];
          sh_r <= {1'b0, sh_r[7:1]};
        end
        S_DATA: begin
          if (last_data) begin
            st_r <= fmt_r[FMT_PEN] ? S_PAR : S_STOP;
            line_r <= fmt_r[FMT_PEN] ? par_r : 1'b1;
            cnt_r <= 3'h0;
          end else begin
            cnt_r <= cnt_r + 3'h1;
            line_r <= sh_r[0];
            par_r <= par_r ^ sh_r[0];
            sh_r <= {1'b0, sh_r[7:1]};
          end
        end
        S_PAR: begin
          st_r <= S_STOP;
          line_r <= 1'b1;
        end
        default: st_r <= S_IDLE;
      endcase
    end
  end

  // ******************************
  // modem link: codec and AC'97
  // ******************************
  logic [7:0] fcnt_r;
  logic [3:0] slot_r, slot_nxt;
  logic [4:0] sbit_r, mcnt_r;
  logic [19:0] msh_r, w1_r, w2_r, cw, aw;
  logic mdat_r, arm_r, dly_r, fsp_r, crdy_r, run_r, pd_r;
  logic [4:0] awr_cnt_r;
  wire cold_reset_indication = mctl_r[MC_COLD_RESET_INDICATION];
  wire msb = ~mctl_r[MC_SHIFT_DIRECTION] | ac97;
  wire m8 = (mode == MD_C8);
  wire [7:0] fnxt = fcnt_r + 8'h01;
  wire fr_start = bclk_rise & (fnxt == 8'h01);
  wire ac_go = fr_start ? crdy_r : run_r;
  wire ac_load = ac97 & bclk_rise & (fr_start | (sbit_r == 5'h00 & slot_r != AC_LAST_SLOT));
  wire c_start = codec & bclk_rise & arm_r & ~dly_r;
  wire awr_long = (awr_cnt_r == 5'(AWR_MIN_CYC));
  assign slot_nxt = fr_start ? 4'h0 : slot_r + 4'h1;
  // sample words; absent data goes out as zeros
  always_comb begin
    cw = 20'h00000;
    aw = 20'h00000;
    if (en_r && hold_full_r) begin
      if (msb) cw = m8 ? {hold_r[7:0], 12'h000} : {hold_r[15:0], 4'h0};
      else cw = m8 ? {12'h000, hold_r[7:0]} : {4'h0, hold_r[15:0]};
      if (ac_go) aw = (slot_nxt == 4'h0) ? {hold_r[15:0], 4'h0} : hold_r;
    end
  end
  always_comb begin
    hold_take = 1'b0;
    if (uart) hold_take = bit_tick & can_start & (st_r == S_IDLE | stop_done);
    else if (codec) hold_take = c_start & en_r & hold_full_r;
    else hold_take = ac_load & ac_go & en_r & hold_full_r;
  end
  // AC'97 frame counter on incoming bit clock; idle while cold reset
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) fcnt_r <= 8'h00;
    else if (!ac97 || !cold_reset_indication) fcnt_r <= 8'h00;
    else if (bclk_rise) fcnt_r <= fnxt;
  end
  // codec ready: first received bit, sampled on the falling edge
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      crdy_r <= 1'b0;
      run_r <= 1'b0;
    end else if (!ac97 || !cold_reset_indication) begin
      crdy_r <= 1'b0;
      run_r <= 1'b0;
    end else begin
      if (bclk_fall && fcnt_r == 8'h01) crdy_r <= rxd_s;
      if (fr_start) run_r <= crdy_r;
    end
  end
  // serial shifter for codec samples and AC'97 slots
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      msh_r <= 20'h00000;
      mcnt_r <= 5'h00;
      mdat_r <= 1'b0;
      arm_r <= 1'b0;
      dly_r <= 1'b0;
      fsp_r <= 1'b0;
      slot_r <= AC_LAST_SLOT;
      sbit_r <= 5'h00;
    end else if (tx_rst || uart) begin
      mcnt_r <= 5'h00;
      mdat_r <= 1'b0;
      arm_r <= 1'b0;
      slot_r <= AC_LAST_SLOT;
      sbit_r <= 5'h00;
    end else if (codec) begin
      if (bclk_fall) fsp_r <= fs_s;
      if (bclk_fall && fs_s && !fsp_r) begin
        arm_r <= 1'b1;
        dly_r <= mctl_r[MC_DTS];
      end else if (c_start) begin
        arm_r <= 1'b0;
        mdat_r <= msb ? cw[19] : cw[0];
        msh_r <= msb ? {cw[18:0], 1'b0} : {1'b0, cw[19:1]};
        mcnt_r <= m8 ? 5'h07 : 5'h0F;
      end else if (bclk_rise) begin
        dly_r <= 1'b0;
        if (mcnt_r != 5'h00) begin
          mdat_r <= msb ? msh_r[19] : msh_r[0];
          msh_r <= msb ? {msh_r[18:0], 1'b0} : {1'b0, msh_r[19:1]};
          mcnt_r <= mcnt_r - 5'h01;
        end else mdat_r <= 1'b0;
      end
    end else if (ac_load) begin
      slot_r <= slot_nxt;
      sbit_r <= (slot_nxt == 4'h0) ? AC_SLOT0_TOP : AC_SLOT_TOP;
      mdat_r <= aw[19];
      msh_r <= {aw[18:0], 1'b0};
    end else if (ac97 && bclk_rise) begin
      sbit_r <= sbit_r - 5'h01;
      mdat_r <= msh_r[19];
      msh_r <= {msh_r[18:0], 1'b0};
    end
  end
  // power-down watch over slots 1 to 3; warm reset clears it
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      w1_r <= 20'h00000;
      w2_r <= 20'h00000;
      pd_r <= 1'b0;
      awr_cnt_r <= 5'h00;
    end else begin
      if (!mctl_r[MC_AWR]) awr_cnt_r <= 5'h00;
      else if (!awr_long) awr_cnt_r <= awr_cnt_r + 5'h01;
      if (ac_load && slot_nxt == 4'h1) w1_r <= aw;
      if (ac_load && slot_nxt == 4'h2) w2_r <= aw;
      if (ac_load && slot_nxt == 4'h3 && w1_r[19:17] == 3'h7 && w2_r[19:12] == PD_ADDR && aw[PD_BIT]) begin
        pd_r <= 1'b1;
      end else if (awr_long || !cold_reset_indication) pd_r <= 1'b0;
    end
  end

  // ******************************
  // status and pin outputs
  // ******************************
  assign stat[ST_TRDY] = en_r & ~hold_full_r;
  assign stat[ST_TEMP] = ~hold_full_r & (~uart | st_r == S_IDLE);
  assign stat[ST_CRDY] = crdy_r;
  assign stat[ST_PDN] = pd_r;
  assign stat[ST_RTS] = rts_as_r;
  // pins driven from flops
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      txd <= 1'b1;
      rts_pin <= 1'b1;
    end else begin
      txd <= uart ? (line_r & ~brk_r) : mdat_r;
      if (ac97) rts_pin <= cold_reset_indication & ~mctl_r[MC_AWR] & (fcnt_r < AC_FS_LEN);
      else rts_pin <= ~rts_as_r;
    end
  end
endmodule

// [tb/utx_peer.sv]
// utx_peer: serial peer model, flow control and external baud clock
module utx_peer (
  input wire logic clk_sys, // system clock
  input wire logic hold_off, // peer wants sending paused
  output logic cts_pin, // clear-to-send, low active
  output logic ext_clk, // external baud clock
  output logic rxd // peer serial line, idle mark
);
  // negated clear-to-send while paused, asserted otherwise
  assign cts_pin = hold_off;
  assign rxd = 1'b1;
  // external clock, period 64 system cycles
  initial begin
    ext_clk = 1'b0;
    forever begin
      repeat (32) @(posedge clk_sys);
      ext_clk <= ~ext_clk;
    end
  end
endmodule

// [tb/utx_properties.sv]
// utx_properties: port timing checks for utx_top
module utx_properties (
  input wire logic clk_sys, // system clock
  input wire logic arst_n, // reset, active low
  input wire utx_pkg::utx_axi_req_t axi_req, // bus request
  input wire utx_pkg::utx_axi_rsp_t axi_rsp, // bus response
  input wire logic txd, // serial out
  input wire logic rts_pin // request-to-send
);
  import utx_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // both write channels taken at one edge
  sequence s_wr_taken;
    axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
  endsequence
  property p_wr_ans; s_wr_taken |-> ##2 axi_rsp.bvalid; endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("write answer late");
  property p_b_hold; axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid && $stable(axi_rsp.bresp); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_rd_ans; axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
  property p_r_hold; axi_rsp.rvalid && !axi_req.rready |=> axi_rsp.rvalid && $stable(axi_rsp.rdata); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  property p_refuse; !(axi_rsp.bvalid && axi_rsp.awready) && !(axi_rsp.rvalid && axi_rsp.arready); endproperty
  a_refuse: assert property (p_refuse) else $error("request taken while answering");
  property p_rst_mark; $rose(arst_n) |-> txd && rts_pin; endproperty
  a_rst_mark: assert property (p_rst_mark) else $error("line not idle after reset");
  property p_space; $fell(txd) |=> !txd [*8]; endproperty
  a_space: assert property (p_space) else $error("low bit too short");
  property p_mark; $rose(txd) |=> txd [*8]; endproperty
  a_mark: assert property (p_mark) else $error("high bit too short");
endmodule
bind utx_top utx_properties u_props (.clk_sys(clk_sys), .arst_n(arst_n), .axi_req(axi_req),
  .axi_rsp(axi_rsp), .txd(txd), .rts_pin(rts_pin));

// [tb/uart_tx_baud_modem_link_tb_top.sv]
// uart_tx_baud_modem_link_tb_top: register, framing, clock and flow tests
module uart_tx_baud_modem_link_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import utx_pkg::*;
  logic clk_sys, arst_n, hold_off, ext_clk, cts_pin, rxd, txd, rts_pin, brk;
  utx_axi_req_t axi_req;
  utx_axi_rsp_t axi_rsp;
  int num_errors, num_checks, seed, bit_cyc, nbits, pen, podd, n_start, n_done, k;
  logic [33:0] rd_q[$];
  logic [7:0] ch_q[$];
  logic [6:0] fmts[3] = '{7'h03, 7'h06, 7'h1C};
  int divs[3] = '{96, 64, 1024};
  utx_top DUT (.clk_sys(clk_sys), .arst_n(arst_n), .axi_req(axi_req), .axi_rsp(axi_rsp), .cts_pin(cts_pin),
    .external_timer_clock_pin(ext_clk), .codec_frame_sync_pin(1'b0), .rxd(rxd), .txd(txd), .rts_pin(rts_pin));
  utx_peer peer (.clk_sys(clk_sys), .hold_off(hold_off), .cts_pin(cts_pin), .ext_clk(ext_clk), .rxd(rxd));
  // clock, 40 ns period
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // bus write, both channels offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    axi_req.awaddr <= a;
    axi_req.wdata <= d;
    axi_req.wstrb <= 4'hF;
    {axi_req.awvalid, axi_req.wvalid, axi_req.bready} <= 3'h7;
    do begin
      @(posedge clk_sys);
      if (axi_rsp.awready) axi_req.awvalid <= 1'b0;
      if (axi_rsp.wready) axi_req.wvalid <= 1'b0;
    end while (axi_rsp.bvalid !== 1'b1);
    check(axi_rsp.bresp, a < 8'h20 ? RESP_OK : RESP_ERR);
    axi_req.bready <= 1'b0;
  endtask
  // bus read, expectation queued for the monitor
  task automatic rd(input logic [7:0] a, input logic [33:0] exp);
    rd_q.push_back(exp);
    @(posedge clk_sys);
    axi_req.araddr <= a;
    {axi_req.arvalid, axi_req.rready} <= 2'h3;
    do begin
      @(posedge clk_sys);
      if (axi_rsp.arready) axi_req.arvalid <= 1'b0;
    end while (axi_rsp.rvalid !== 1'b1);
    axi_req.rready <= 1'b0;
  endtask
  always @(posedge clk_sys)
    if (axi_rsp.rvalid === 1'b1 && axi_req.rready === 1'b1) check({axi_rsp.rresp, axi_rsp.rdata}, rd_q.pop_front());
  task automatic send(input logic [7:0] ch);
    int k0;
    k0 = n_start;
    ch_q.push_back(ch);
    wr(ADR_TXB, {24'h0, ch});
    wait (n_start != k0);
  endtask
  task automatic idle();
    wait (ch_q.size() == 0);
    repeat (2 * bit_cyc) @(posedge clk_sys);
  endtask
  // line receiver, compares each frame with the oldest queued character
  initial begin : rx_mon
    logic [7:0] got, e;
    logic p;
    forever begin
      @(negedge txd);
      if (brk || !arst_n) continue;
      n_start++;
      got = 8'h00;
      repeat (bit_cyc / 2) @(posedge clk_sys);
      for (int i = 0; i < nbits; i++) begin
        repeat (bit_cyc) @(posedge clk_sys);
        got[i] = txd;
      end
      if (pen) repeat (bit_cyc) @(posedge clk_sys);
      p = pen ? txd : 1'b0;
      repeat (bit_cyc) @(posedge clk_sys);
      e = ch_q.pop_front();
      check({txd, p, got}, {1'b1, pen ? ^e ^ podd[0] : 1'b0, e});
      n_done++;
    end
  end
  // watchdog
  initial begin
    #3000000;
    num_errors++;
    report_and_stop();
  end
  initial begin
    seed = 4;
    axi_req = '0;
    {hold_off, brk, arst_n} = 3'h0;
    bit_cyc = 96;
    nbits = 8;
    repeat (3) @(posedge clk_sys);
    arst_n <= 1'b1;
    rd(ADR_FMT, {RESP_OK, 25'h0, FMT_RST});
    rd(ADR_MCTL, {RESP_OK, 24'h0, MC_RST});
    rd(ADR_DIVH, {RESP_OK, 24'h0, DIVH_RST});
    rd(8'h40, {RESP_ERR, 32'h0});
    wr(8'h40, 32'h0);
    wr(ADR_MCTL, 32'h0);
    wr(ADR_MCTL, 32'h80);
    wr(ADR_DIVL, 32'h3);
    wr(ADR_CMD, {29'h0, C_EN});
    rd(ADR_STAT, {RESP_OK, 32'h3});
    $display("test registers done");
    foreach (fmts[j]) begin
      idle();
      nbits = fmts[j][1:0] + 5;
      pen = fmts[j][FMT_PEN];
      podd = fmts[j][FMT_PODD];
      wr(ADR_FMT, {25'h0, fmts[j]});
      repeat (3) send($random(seed) & ((1 << nbits) - 1));
    end
    $display("test formats done");
    foreach (divs[j]) begin
      idle();
      if (j == 0) wr(ADR_FMT, {25'h0, FMT_RST});
      {nbits, pen, podd} = {32'd8, 64'd0};
      bit_cyc = divs[j];
      wr(ADR_CSRC, j);
      send($random(seed));
    end
    idle();
    bit_cyc = 96;
    wr(ADR_CSRC, 32'h0);
    $display("test clock sources done");
    wr(ADR_FMT, 32'h23);
    k = n_start;
    hold_off <= 1'b1;
    ch_q.push_back(8'hA5);
    wr(ADR_TXB, 32'hA5);
    repeat (600) @(posedge clk_sys);
    check(n_start - k, 0);
    hold_off <= 1'b0;
    wait (n_start != k);
    hold_off <= 1'b1;
    ch_q.push_back(8'h5A);
    wr(ADR_TXB, 32'h5A);
    repeat (1500) @(posedge clk_sys);
    check(n_start - k, 1);
    hold_off <= 1'b0;
    idle();
    $display("test flow control done");
    brk = 1'b1;
    hold_off <= 1'b1;
    wr(ADR_CMD, {29'h0, C_BRK_ON});
    repeat (300) @(posedge clk_sys);
    check(txd, 1'b0);
    wr(ADR_TXB, 32'h77);
    wr(ADR_CMD, {29'h0, C_RST});
    rd(ADR_STAT, {RESP_OK, 32'h2});
    wr(ADR_CMD, {29'h0, C_EN});
    wr(ADR_CMD, {29'h0, C_BRK_OFF});
    hold_off <= 1'b0;
    repeat (300) @(posedge clk_sys);
    check(txd, 1'b1);
    brk = 1'b0;
    $display("test break done");
    wr(ADR_FMT, 32'h43);
    wr(ADR_CMD, {29'h0, C_RTS_ON});
    repeat (2) @(posedge clk_sys);
    check(rts_pin, 1'b0);
    k = n_done;
    send(8'h3C);
    wr(ADR_CMD, {29'h0, C_DIS});
    wait (n_done != k);
    repeat (bit_cyc) @(posedge clk_sys);
    check(rts_pin, 1'b0);
    repeat (bit_cyc) @(posedge clk_sys);
    check(rts_pin, 1'b1);
    rd(ADR_STAT, {RESP_OK, 32'h2});
    $display("test disable done");
    @(posedge clk_sys);
    report_and_stop();
  end
endmodule
